// file: hdl/rsf_stats.sv
// Receive frame error statistics, false-detection counter, length limits.
// Assumes rx_done is a one-cycle pulse with all flags valid in that cycle,
// and an APB master on the same clock.
`timescale 1ns/1ps

module rsf_stats import rsf_pkg::*; #(
  parameter int ADDR_W = 18,
  parameter int LEN_W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  input wire logic rx_done,
  input wire logic mac_crc32_bad,
  input wire logic pay_crc8_bad,
  input wire logic cipher_crc8_bad,
  input wire logic hdr_crc8_bad,
  input wire logic phy_crc8_bad,
  input wire logic bad_protocol,
  input wire logic bad_length,
  input wire logic bad_padding,
  input wire logic bad_header_type,
  input wire logic bad_security,
  input wire logic [1:0] rx_modulation,
  input wire logic rx_viterbi,
  input wire logic [LEN_W-1:0] rx_len_field,
  output logic len_drop
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [15:0] idx;
  logic aligned;
  logic wr_en;
  logic rd_setup;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [31:0] prdata_reg;

  assign idx = 16'(paddr[ADDR_W-1:2]);
  assign aligned = (paddr[1:0] == 2'h0);
  assign wr_en = psel && penable && pwrite && aligned;
  assign rd_setup = psel && !penable;
  // no wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_hit;
  assign prdata = prdata_reg;

  function automatic logic wr_hit(input logic en, input logic [15:0] a,
                                  input logic [15:0] target);
    wr_hit = en && (a == target);
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] cnt_reg [0:RSF_NUM_CNT-1];
  logic [15:0] cnt_next [0:RSF_NUM_CNT-1];
  logic [7:0] fd_sel_reg;
  logic [7:0] lim_bpsk_plain_reg;
  logic [7:0] lim_bpsk_coded_reg;
  logic [7:0] lim_qpsk_plain_reg;
  logic [RSF_IRQ_W-1:0] irq_sts_reg;
  logic [RSF_IRQ_W-1:0] irq_mask_reg;
  logic len_drop_reg;

  // ----------------------------------------------------------------
  // receive events
  // ----------------------------------------------------------------
  logic [RSF_FD_W-1:0] fd_faults;
  logic fd_event;
  logic [RSF_NUM_CNT-1:0] cnt_ev;
  logic [RSF_LIM_W-1:0] lim_sel;
  logic lim_used;
  logic over_len;

  always_comb begin
    fd_faults = '0;
    fd_faults[RSF_FD_HDR_CRC8] = hdr_crc8_bad;
    fd_faults[RSF_FD_PROTOCOL] = bad_protocol;
    fd_faults[RSF_FD_LENGTH] = bad_length;
    fd_faults[RSF_FD_PADDING] = bad_padding;
    fd_faults[RSF_FD_HDR_TYPE] = bad_header_type;
    fd_faults[RSF_FD_SECURITY] = bad_security;
  end

  // a frame with a failed PHY CRC8 is already dropped, never a false detection
  assign fd_event = rx_done && !phy_crc8_bad
                    && |(fd_faults & fd_sel_reg[RSF_FD_W-1:0]);

  assign cnt_ev[0] = rx_done && mac_crc32_bad;
  assign cnt_ev[1] = rx_done && pay_crc8_bad;
  assign cnt_ev[2] = rx_done && cipher_crc8_bad;
  assign cnt_ev[3] = rx_done && hdr_crc8_bad;
  assign cnt_ev[4] = rx_done && phy_crc8_bad;
  assign cnt_ev[5] = fd_event;

  // ----------------------------------------------------------------
  // length limits
  // ----------------------------------------------------------------
  // only the low six bits set the limit; the upper two are kept for readback
  always_comb begin
    lim_sel = '0;
    lim_used = 1'b0;
    if (rx_modulation == RSF_MOD_BPSK && !rx_viterbi) begin
      lim_sel = lim_bpsk_plain_reg[RSF_LIM_W-1:0];
      lim_used = 1'b1;
    end else if (rx_modulation == RSF_MOD_BPSK && rx_viterbi) begin
      lim_sel = lim_bpsk_coded_reg[RSF_LIM_W-1:0];
      lim_used = 1'b1;
    end else if (rx_modulation == RSF_MOD_QPSK && !rx_viterbi) begin
      lim_sel = lim_qpsk_plain_reg[RSF_LIM_W-1:0];
      lim_used = 1'b1;
    end
  end

  assign over_len = rx_done && lim_used && (rx_len_field > LEN_W'(lim_sel));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      len_drop_reg <= 1'b0;
    end else begin
      len_drop_reg <= over_len;
    end
  end
  assign len_drop = len_drop_reg;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // a write and an event in the same cycle: the event adds onto the written value
  always_comb begin
    for (int i = 0; i < RSF_NUM_CNT; i++) begin
      cnt_next[i] = cnt_reg[i];
      if (wr_hit(wr_en, idx, RSF_CNT_IDX[i])) begin
        cnt_next[i][15:8] = pwdata[7:0];
      end
      if (wr_hit(wr_en, idx, 16'(RSF_CNT_IDX[i] + 16'h0001))) begin
        cnt_next[i][7:0] = pwdata[7:0];
      end
      cnt_next[i] = 16'(cnt_next[i] + {15'h0000, cnt_ev[i]});
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < RSF_NUM_CNT; i++) begin
        cnt_reg[i] <= RSF_CNT_RST;
      end
    end else begin
      for (int i = 0; i < RSF_NUM_CNT; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fd_sel_reg <= RSF_FD_SEL_RST;
      lim_bpsk_plain_reg <= RSF_LEN_LIM_RST;
      lim_bpsk_coded_reg <= RSF_LEN_LIM_RST;
      lim_qpsk_plain_reg <= RSF_LEN_LIM_RST;
      irq_mask_reg <= RSF_IRQ_RST;
    end else begin
      if (wr_hit(wr_en, idx, RSF_IDX_FD_SELECT)) begin
        // reserved bits 7:6 stay zero
        fd_sel_reg <= {2'h0, pwdata[5:0]};
      end
      if (wr_hit(wr_en, idx, RSF_IDX_BPSK_PLAIN)) begin
        lim_bpsk_plain_reg <= pwdata[7:0];
      end
      if (wr_hit(wr_en, idx, RSF_IDX_BPSK_CODED)) begin
        lim_bpsk_coded_reg <= pwdata[7:0];
      end
      if (wr_hit(wr_en, idx, RSF_IDX_QPSK_PLAIN)) begin
        lim_qpsk_plain_reg <= pwdata[7:0];
      end
      if (wr_hit(wr_en, idx, RSF_IDX_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[RSF_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  logic [RSF_IRQ_W-1:0] irq_set;
  logic [RSF_IRQ_W-1:0] irq_clr;

  assign irq_set = {over_len, cnt_ev};
  assign irq_clr = wr_hit(wr_en, idx, RSF_IDX_IRQ_STATUS) ? pwdata[RSF_IRQ_W-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_sts_reg <= RSF_IRQ_RST;
    end else begin
      // set beats write-one-to-clear so no event is lost
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_sts_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = aligned;
    if (idx == RSF_IDX_FD_SELECT) begin
      rd_byte = fd_sel_reg;
    end else if (idx == RSF_IDX_BPSK_PLAIN) begin
      rd_byte = lim_bpsk_plain_reg;
    end else if (idx == RSF_IDX_BPSK_CODED) begin
      rd_byte = lim_bpsk_coded_reg;
    end else if (idx == RSF_IDX_QPSK_PLAIN) begin
      rd_byte = lim_qpsk_plain_reg;
    end else if (idx == RSF_IDX_IRQ_STATUS) begin
      rd_byte = {1'b0, irq_sts_reg};
    end else if (idx == RSF_IDX_IRQ_MASK) begin
      rd_byte = {1'b0, irq_mask_reg};
    end else begin
      rd_hit = 1'b0;
      for (int i = 0; i < RSF_NUM_CNT; i++) begin
        if (idx == RSF_CNT_IDX[i]) begin
          rd_byte = cnt_reg[i][15:8];
          rd_hit = aligned;
        end else if (idx == 16'(RSF_CNT_IDX[i] + 16'h0001)) begin
          rd_byte = cnt_reg[i][7:0];
          rd_hit = aligned;
        end
      end
    end
  end

  // sampled in the setup cycle so the access phase sees a flip-flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_reg <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [RSF_NUM_CNT-1:0] cnt_wr;
  always_comb begin
    for (int i = 0; i < RSF_NUM_CNT; i++) begin
      cnt_wr[i] = wr_hit(wr_en, idx, RSF_CNT_IDX[i])
                  || wr_hit(wr_en, idx, 16'(RSF_CNT_IDX[i] + 16'h0001));
    end
  end

  for (genvar g = 0; g < 5; g++) begin : g_drop_chk
    chk_drop_count: assert property (@(posedge clk) disable iff (rst)
      cnt_ev[g] && !cnt_wr[g] |=> cnt_reg[g] == 16'($past(cnt_reg[g]) + 16'h0001))
      else $error("drop counter did not step by one");
  end

  chk_count_holds: assert property (@(posedge clk) disable iff (rst)
    !rx_done && !(|cnt_wr) |=> cnt_reg[0] == $past(cnt_reg[0]) && cnt_reg[5] == $past(cnt_reg[5]))
    else $error("counter changed without event or write");

  chk_false_detect: assert property (@(posedge clk) disable iff (rst)
    rx_done && phy_crc8_bad && !cnt_wr[5] |=> $stable(cnt_reg[5]))
    else $error("false detection counted on a bad phy crc");

  for (genvar j = 0; j < RSF_FD_W; j++) begin : g_fd_chk
    chk_fd_select: assert property (@(posedge clk) disable iff (rst)
      rx_done && !phy_crc8_bad && fd_sel_reg[j] && fd_faults[j] && !cnt_wr[5]
      |=> cnt_reg[5] == 16'($past(cnt_reg[5]) + 16'h0001))
      else $error("enabled field fault not counted");
  end

  chk_len_bpsk: assert property (@(posedge clk) disable iff (rst)
    rx_done && rx_modulation == RSF_MOD_BPSK && !rx_viterbi
    && rx_len_field > LEN_W'(lim_bpsk_plain_reg[RSF_LIM_W-1:0]) |=> len_drop)
    else $error("plain bpsk over-length not discarded");

  chk_len_coded: assert property (@(posedge clk) disable iff (rst)
    rx_done && rx_modulation == RSF_MOD_BPSK && rx_viterbi
    && rx_len_field <= LEN_W'(lim_bpsk_coded_reg[RSF_LIM_W-1:0]) |=> !len_drop)
    else $error("coded bpsk within limit discarded");

  chk_len_qpsk: assert property (@(posedge clk) disable iff (rst)
    rx_done && rx_modulation == RSF_MOD_QPSK && !rx_viterbi
    && rx_len_field > LEN_W'(lim_qpsk_plain_reg[RSF_LIM_W-1:0])
    |=> len_drop ##1 (!len_drop || $past(rx_done)))
    else $error("plain qpsk over-length not discarded");

  chk_byte_order: assert property (@(posedge clk) disable iff (rst)
    rd_setup && idx == RSF_IDX_MAC_CRC32 |=> prdata[7:0] == $past(cnt_reg[0][15:8]))
    else $error("counter high byte not at lower address");

endmodule

// file: shared/rsf_pkg.sv
// Constants for the receive-side frame error statistics block.
// Assumes an APB slave in which register index i sits at byte address 4*i.
package rsf_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int RSF_NUM_CNT = 6;
  localparam logic [15:0] RSF_IDX_MAC_CRC32 = 16'hFEBA;
  localparam logic [15:0] RSF_IDX_PAY_CRC8 = 16'hFEBC;
  localparam logic [15:0] RSF_IDX_CIPHER_CRC8 = 16'hFEBE;
  localparam logic [15:0] RSF_IDX_HDR_CHECK = 16'hFEC0;
  localparam logic [15:0] RSF_IDX_PHY_CRC8 = 16'hFEC2;
  localparam logic [15:0] RSF_IDX_FD_SELECT = 16'hFEC4;
  localparam logic [15:0] RSF_IDX_FD_COUNT = 16'hFEC5;
  localparam logic [15:0] RSF_IDX_BPSK_PLAIN = 16'hFEC8;
  localparam logic [15:0] RSF_IDX_BPSK_CODED = 16'hFEC9;
  localparam logic [15:0] RSF_IDX_QPSK_PLAIN = 16'hFECA;
  localparam logic [15:0] RSF_IDX_IRQ_STATUS = 16'hFED0;
  localparam logic [15:0] RSF_IDX_IRQ_MASK = 16'hFED1;

  // high byte of each counter at its index, low byte at index + 1
  localparam logic [15:0] RSF_CNT_IDX [0:RSF_NUM_CNT-1] = '{
    RSF_IDX_MAC_CRC32, RSF_IDX_PAY_CRC8, RSF_IDX_CIPHER_CRC8,
    RSF_IDX_HDR_CHECK, RSF_IDX_PHY_CRC8, RSF_IDX_FD_COUNT};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RSF_CNT_RST = 16'h0000;
  localparam logic [7:0] RSF_FD_SEL_RST = 8'h10;
  localparam logic [7:0] RSF_LEN_LIM_RST = 8'hFF;
  localparam logic [6:0] RSF_IRQ_RST = 7'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RSF_FD_HDR_CRC8 = 5;
  localparam int RSF_FD_PROTOCOL = 4;
  localparam int RSF_FD_LENGTH = 3;
  localparam int RSF_FD_PADDING = 2;
  localparam int RSF_FD_HDR_TYPE = 1;
  localparam int RSF_FD_SECURITY = 0;
  localparam int RSF_FD_W = 6;
  localparam int RSF_LIM_W = 6;
  // status bits 0..5 follow the counters, bit 6 is the length discard
  localparam int RSF_IRQ_LEN_DROP = 6;
  localparam int RSF_IRQ_W = 7;

  // ----------------------------------------------------------------
  // modulation codes from the receive chain
  // ----------------------------------------------------------------
  localparam logic [1:0] RSF_MOD_BPSK = 2'h0;
  localparam logic [1:0] RSF_MOD_QPSK = 2'h1;
  localparam logic [1:0] RSF_MOD_8PSK = 2'h2;

endpackage

// file: tb/rsf_rx_model.sv
// Receive chain model: raises one end-of-message pulse per call.
// Assumes the block samples every qualifier in the rx_done cycle.
`timescale 1ns/1ps

module rsf_rx_model (
  input wire logic clk,
  input wire logic len_drop,
  output logic rx_done,
  output logic [9:0] flags,
  output logic [1:0] modu,
  output logic vit,
  output logic [5:0] len
);
  initial begin
    rx_done = 1'b0;
    flags = 10'h000;
    modu = 2'h0;
    vit = 1'b0;
    len = 6'h00;
  end

  // flags: mac32 pay8 cip8 phy8, then field faults in select-bit order
  task automatic send(input logic [9:0] f, input logic [1:0] m, input logic v,
                      input logic [5:0] l, output logic drop);
    @(posedge clk);
    rx_done <= 1'b1;
    flags <= f;
    modu <= m;
    vit <= v;
    len <= l;
    @(posedge clk);
    rx_done <= 1'b0;
    // stale qualifiers flip so nothing relies on them holding
    flags <= ~f;
    modu <= ~m;
    vit <= ~v;
    len <= ~l;
    #1 drop = len_drop;
  endtask
endmodule

// file: tb/tb_rsf_stats.sv
// Self-checking bench for the receive error statistics block.
// Assumes APB on clk with zero wait states and the rx model beside it.
`timescale 1ns/1ps

module tb_rsf_stats import rsf_pkg::*;;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, len_drop;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rx_done, vit;
  logic [9:0] fl;
  logic [1:0] modu;
  logic [5:0] ln;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  rsf_stats DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq), .rx_done(rx_done),
    .mac_crc32_bad(fl[9]), .pay_crc8_bad(fl[8]), .cipher_crc8_bad(fl[7]),
    .phy_crc8_bad(fl[6]), .hdr_crc8_bad(fl[5]), .bad_protocol(fl[4]),
    .bad_length(fl[3]), .bad_padding(fl[2]), .bad_header_type(fl[1]),
    .bad_security(fl[0]), .rx_modulation(modu), .rx_viterbi(vit),
    .rx_len_field(ln), .len_drop(len_drop));
  rsf_rx_model rx (.clk(clk), .len_drop(len_drop), .rx_done(rx_done), .flags(fl),
    .modu(modu), .vit(vit), .len(ln));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {i, 2'h0}, d, r, e);
  endtask

  task automatic rd(input logic [15:0] i, output logic [31:0] r);
    logic e;
    apb(1'b0, {i, 2'h0}, 32'h0, r, e);
  endtask

  task automatic rd16(input logic [15:0] i, output logic [31:0] v);
    logic [31:0] h, l;
    rd(i, h);
    rd(i + 16'h1, l);
    v = {h[15:0], l[7:0]};
  endtask

  task automatic ev(input logic [9:0] f);
    logic d;
    rx.send(f, RSF_MOD_BPSK, 1'b0, 6'h01, d);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    for (int i = 'hFEBA; i <= 'hFEC6; i++) begin
      rd(i[15:0], r);
      chk(r, (i == 'hFEC4) ? {24'h0, RSF_FD_SEL_RST} : 32'h0);
    end
    for (int i = 'hFEC8; i <= 'hFECA; i++) begin
      rd(i[15:0], r);
      chk(r, {24'h0, RSF_LEN_LIM_RST});
    end
    apb(1'b1, {16'hFEC7, 2'h0}, 32'h55, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, {16'hFEC7, 2'h0}, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b0, {RSF_IDX_FD_SELECT, 2'h1}, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(RSF_IDX_FD_SELECT, 32'hFF);
    rd(RSF_IDX_FD_SELECT, r);
    chk(r, 32'h3F);
  endtask

  task automatic t_counters;
    logic [31:0] v;
    logic [9:0] f [0:4] = '{10'h200, 10'h100, 10'h080, 10'h020, 10'h040};
    wr(RSF_IDX_FD_SELECT, 32'h10);
    for (int i = 0; i < 5; i++) begin
      repeat (i + 1) ev(f[i]);
    end
    for (int i = 0; i < 5; i++) begin
      rd16(RSF_CNT_IDX[i], v);
      chk(v, i + 1);
    end
    rd16(RSF_IDX_FD_COUNT, v);
    chk(v, 32'h0);
  endtask

  task automatic t_hold;
    logic [31:0] v;
    wr(RSF_IDX_MAC_CRC32, 32'h00);
    wr(RSF_IDX_MAC_CRC32 + 16'h1, 32'hFF);
    ev(10'h200);
    repeat (20) @(posedge clk);
    rd16(RSF_IDX_MAC_CRC32, v);
    chk(v, 32'h0100);
    wr(RSF_IDX_MAC_CRC32, 32'h00);
    rd16(RSF_IDX_MAC_CRC32, v);
    chk(v, 32'h0);
  endtask

  task automatic t_false;
    logic [31:0] v;
    logic [9:0] f;
    for (int b = 0; b < RSF_FD_W; b++) begin
      f = 10'h1 << b;
      wr(RSF_IDX_FD_SELECT, {26'h0, f[5:0]});
      ev(f);
      ev(f | 10'h040);
      ev(10'h1 << ((b + 1) % RSF_FD_W));
      rd16(RSF_IDX_FD_COUNT, v);
      chk(v, b + 1);
    end
  endtask

  task automatic t_len;
    logic d;
    logic [1:0] m [0:2] = '{RSF_MOD_BPSK, RSF_MOD_BPSK, RSF_MOD_QPSK};
    for (int k = 0; k < 3; k++) begin
      wr(RSF_IDX_BPSK_PLAIN + k[15:0], 32'd10 + 32'd10 * k);
    end
    for (int k = 0; k < 3; k++) begin
      rx.send(10'h0, m[k], k == 1, 6'd10 + 6'd10 * k[5:0], d);
      chk({31'h0, d}, 32'h0);
      rx.send(10'h0, m[k], k == 1, 6'd11 + 6'd10 * k[5:0], d);
      chk({31'h0, d}, 32'h1);
    end
    rx.send(10'h0, RSF_MOD_8PSK, 1'b0, 6'h3F, d);
    chk({31'h0, d}, 32'h0);
  endtask

  task automatic t_irq;
    logic [31:0] r;
    logic d;
    wr(RSF_IDX_IRQ_STATUS, 32'h7F);
    rd(RSF_IDX_IRQ_STATUS, r);
    chk(r, 32'h0);
    wr(RSF_IDX_IRQ_MASK, 32'h01);
    #1 chk({31'h0, irq}, 32'h0);
    ev(10'h200);
    #1 chk({31'h0, irq}, 32'h1);
    rd(RSF_IDX_IRQ_STATUS, r);
    chk(r, 32'h01);
    wr(RSF_IDX_IRQ_MASK, 32'h00);
    #1 chk({31'h0, irq}, 32'h0);
    wr(RSF_IDX_IRQ_MASK, 32'h01);
    wr(RSF_IDX_IRQ_STATUS, 32'h01);
    #1 chk({31'h0, irq}, 32'h0);
    // every drop source plus an over-length discard in one message
    wr(RSF_IDX_IRQ_STATUS, 32'h7F);
    rx.send(10'h3E0, RSF_MOD_BPSK, 1'b0, 6'h3F, d);
    rd(RSF_IDX_IRQ_STATUS, r);
    chk(r, 32'h5F);
    // header fault with good phy crc: header drop and false detection
    wr(RSF_IDX_IRQ_STATUS, 32'h7F);
    ev(10'h020);
    rd(RSF_IDX_IRQ_STATUS, r);
    chk(r, 32'h28);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic test_done;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // bound well above the scenarios' few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_counters();
    t_hold();
    t_false();
    t_len();
    t_irq();
    test_done();
  end
endmodule
